// >>> scsp_defs.vh
// constants for the serial control signal path
`ifndef SCSP_DEFS_VH
`define SCSP_DEFS_VH
`define SCSP_MODE_W 3
`define SCSP_MODE_V35 3'h0
`define SCSP_MODE_V28 3'h1
`define SCSP_MODE_V10 3'h2
`define SCSP_ROLE_DTE 1'h0
`define SCSP_ROLE_DCE 1'h1
`define SCSP_RST_OUT 1'h0
`endif

// >>> scsp_sample_reg.v
// sampling register stepped by rising edges of the external sampling clock
`timescale 1ns/100ps
`include "scsp_defs.vh"
module scsp_sample_reg #(
  parameter WIDTH = 4
)
(
  input wire i_clk,
  input wire i_resetn,
  input wire i_sample_clk,
  input wire [WIDTH-1:0] i_d,
  output reg [WIDTH-1:0] o_q
);
  reg sclk_prev;
  wire sclk_rise;

  assign sclk_rise = i_sample_clk & ~sclk_prev;

  always @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      sclk_prev <= 1'h0;
      o_q <= {WIDTH{`SCSP_RST_OUT}};
    end
    else
    begin
      sclk_prev <= i_sample_clk;
      if (sclk_rise)
        o_q <= i_d;
    end
  end
endmodule

// >>> scsp_control_path.v
// control signal path: DCE line idle in loopback, latched mode, loopback, line drive
`timescale 1ns/100ps
`include "scsp_defs.vh"
module scsp_control_path
(
  input wire i_clk,
  input wire i_resetn,
  input wire i_latch_select,
  input wire i_sample_clk,
  input wire i_loopback_n,
  input wire i_role_select,
  input wire i_output_enable_n,
  input wire [`SCSP_MODE_W-1:0] i_interface_mode,
  input wire i_transmitter4_digital_in,
  input wire i_transmitter5_digital_in,
  input wire i_transmitter8_digital_in,
  input wire i_receiver5_line_in,
  input wire i_receiver8_line_in,
  output reg o_transmitter4_positive_out,
  output reg o_transmitter4_negative_out,
  output reg o_transmitter4_negative_oe,
  output reg o_transmitter5_positive_out,
  output reg o_transmitter5_negative_out,
  output reg o_transmitter5_negative_oe,
  output reg o_transmitter8_line_out,
  output reg o_receiver5_digital_out,
  output reg o_receiver8_digital_out,
  output reg o_receiver8_digital_oe,
  output reg o_loopback_active
);
  // ---------------------------------------------
  // helpers
  // ---------------------------------------------
  function single_ended;
    input [`SCSP_MODE_W-1:0] mode;
    begin
      single_ended = (mode == `SCSP_MODE_V35) || (mode == `SCSP_MODE_V28) ||
        (mode == `SCSP_MODE_V10);
    end
  endfunction

  // receive source: line level, or the terminal's transmit bit in loopback
  function loop_source;
    input line_bit;
    input term_bit;
    input loop;
    begin
      if (loop)
        loop_source = term_bit;
      else
        loop_source = line_bit;
    end
  endfunction

  // negative rail: inverse when differential, parked low when single-ended
  function negative_rail;
    input data;
    input single;
    begin
      if (single)
        negative_rail = 1'h0;
      else
        negative_rail = ~data;
    end
  endfunction

  // a DCE in loopback keeps transmitters 5 and 8 idle
  function line_idle;
    input loop;
    input dce;
    begin
      line_idle = loop & dce;
    end
  endfunction

  // ---------------------------------------------
  // decoded controls
  // ---------------------------------------------
  // pins left open read as transparent and loopback off; pulls sit at the pads
  wire loop_on;
  wire is_dce;
  wire se;

  assign loop_on = ~i_loopback_n;
  assign is_dce = (i_role_select == `SCSP_ROLE_DCE);
  assign se = single_ended(i_interface_mode);

  // ---------------------------------------------
  // receive and transmit path sources
  // ---------------------------------------------
  reg [3:0] next_rx;

  always @*
  begin
    next_rx[0] = loop_source(i_receiver5_line_in, i_transmitter5_digital_in, loop_on);
    next_rx[1] = loop_source(i_receiver8_line_in, i_transmitter8_digital_in, loop_on);
    next_rx[2] = i_transmitter5_digital_in;
    next_rx[3] = i_transmitter8_digital_in;
  end

  // ---------------------------------------------
  // sampling register
  // ---------------------------------------------
  // sampling clock is edge detected, so it must stay high and low a cycle each
  wire [3:0] sampled;

  scsp_sample_reg #(.WIDTH(4)) u_sample
  (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_sample_clk(i_sample_clk),
    .i_d(next_rx),
    .o_q(sampled)
  );

  // ---------------------------------------------
  // mode selection
  // ---------------------------------------------
  reg tx5_sel;
  reg tx8_sel;
  reg rx5_sel;
  reg rx8_sel;

  always @*
  begin
    if (i_latch_select)
    begin
      tx5_sel = sampled[2];
      tx8_sel = sampled[3];
      rx5_sel = sampled[0];
      rx8_sel = sampled[1];
    end
    else
    begin
      tx5_sel = i_transmitter5_digital_in;
      tx8_sel = i_transmitter8_digital_in;
      rx5_sel = next_rx[0];
      rx8_sel = next_rx[1];
    end
  end

  // ---------------------------------------------
  // transmitter 4 line drive
  // ---------------------------------------------
  always @*
  begin
    o_transmitter4_positive_out = i_transmitter4_digital_in;
    o_transmitter4_negative_out = negative_rail(i_transmitter4_digital_in, se);
    o_transmitter4_negative_oe = ~se;
  end

  // ---------------------------------------------
  // transmitter 5 line drive
  // ---------------------------------------------
  always @*
  begin
    if (line_idle(loop_on, is_dce))
    begin
      o_transmitter5_positive_out = 1'h0;
      o_transmitter5_negative_out = 1'h0;
    end
    else
    begin
      o_transmitter5_positive_out = tx5_sel;
      o_transmitter5_negative_out = negative_rail(tx5_sel, se);
    end
    // enable follows the mode even while the line is idled
    o_transmitter5_negative_oe = ~se;
  end

  // ---------------------------------------------
  // transmitter 8 line drive
  // ---------------------------------------------
  // single-ended only, no negative rail
  always @*
  begin
    if (line_idle(loop_on, is_dce))
      o_transmitter8_line_out = 1'h0;
    else
      o_transmitter8_line_out = tx8_sel;
  end

  // ---------------------------------------------
  // receiver 5 output
  // ---------------------------------------------
  always @*
  begin
    o_receiver5_digital_out = rx5_sel;
  end

  // ---------------------------------------------
  // receiver 8 output and enable
  // ---------------------------------------------
  // the pad releases the pin while the enable is low
  always @*
  begin
    o_receiver8_digital_out = rx8_sel;
    o_receiver8_digital_oe = ~i_output_enable_n;
  end

  // ---------------------------------------------
  // loopback status
  // ---------------------------------------------
  always @*
  begin
    o_loopback_active = loop_on;
  end
endmodule

// >>> scsp_cp_chk_assertions.sv
// control path port assertions
`timescale 1ns/100ps
module scsp_cp_chk
(
  input logic i_clk, i_resetn, i_latch_select, i_sample_clk, i_loopback_n, i_role_select, i_output_enable_n,
  input logic [2:0] i_interface_mode,
  input logic i_transmitter5_digital_in, o_transmitter5_negative_oe, o_transmitter5_positive_out,
  input logic o_receiver5_digital_out, o_receiver8_digital_oe, o_loopback_active
);
  wire lb = i_loopback_n, lat = i_latch_select & lb, sc = i_sample_clk;
  wire t5 = o_transmitter5_positive_out, t5i = i_transmitter5_digital_in, r5 = o_receiver5_digital_out;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  a_oe_map: assert property (o_receiver8_digital_oe == !i_output_enable_n) else $error("oe");
  a_loop_flag: assert property (o_loopback_active == !lb) else $error("lb");
  a_rx_hold: assert property (lat && !$rose(sc) ##1 lat |-> $stable(r5)) else $error("rh");
  a_tx_hold: assert property (lat && !$rose(sc) ##1 lat |-> $stable(t5)) else $error("th");
  a_tx_load: assert property (lat && $rose(sc) ##1 lat |-> t5 == $past(t5i)) else $error("tl");
  a_pass_thru: assert property (!i_latch_select && lb |-> t5 == t5i) else $error("tp");
  a_single_end: assert property (i_interface_mode < 3 |-> !o_transmitter5_negative_oe) else $error("se");
  a_dce_loop: assert property (!lb && i_role_select && !i_latch_select |-> r5 == t5i && !t5) else $error("dl");
endmodule
bind scsp_control_path scsp_cp_chk u_chk(.*);

// >>> scsp_term.sv
// terminal equipment model driving the transmitter inputs
`timescale 1ns/100ps
module scsp_term(input logic i_role, input logic [5:0] i_sig, output logic [2:0] o_tx);
  assign o_tx = i_role ? {i_sig[5], i_sig[3], i_sig[1]} : {i_sig[4], i_sig[2], i_sig[0]};
endmodule

// >>> scsp_control_path_tb.sv
// bench for the control path
`timescale 1ns/100ps
module scsp_control_path_tb;
  logic i_clk = 0, i_resetn = 0, i_latch_select = 0, i_sample_clk = 0, i_loopback_n = 1, i_role_select = 0;
  logic i_output_enable_n = 0, i_receiver5_line_in = 0, i_receiver8_line_in = 0;
  logic [2:0] i_interface_mode = 0;
  logic [5:0] sig = 0;
  int errors = 0, compares = 0, cyc = 0;
  wire i_transmitter4_digital_in, i_transmitter5_digital_in, i_transmitter8_digital_in, o_transmitter4_positive_out;
  wire o_transmitter4_negative_out, o_transmitter4_negative_oe, o_transmitter5_positive_out, o_transmitter5_negative_out;
  wire o_transmitter5_negative_oe, o_transmitter8_line_out, o_receiver5_digital_out, o_receiver8_digital_out;
  wire o_receiver8_digital_oe, o_loopback_active;
  scsp_term term(.i_role(i_role_select), .i_sig(sig),
    .o_tx({i_transmitter8_digital_in, i_transmitter5_digital_in, i_transmitter4_digital_in}));
  scsp_control_path dut(.*);
  task chk(input string n, input logic s, e);
    compares++;
    if (s !== e) begin errors++; $display("BAD %s expected %b seen %b", n, e, s); end
  endtask
  task step(input int n); repeat (n) @(posedge i_clk); #2; endtask
  task complete_run;
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial forever #25 i_clk = ~i_clk;
  always @(posedge i_clk) if (++cyc == 2000) begin errors++; complete_run; end
  initial
  begin
    step(12);
    i_resetn = 1;
    for (int m = 0; m < 8; m++)
    begin
      step(1);
      {i_output_enable_n, i_receiver8_line_in, i_role_select, i_interface_mode} = {3'(m), 3'(m)};
      sig = 6'(m * 11);
      #1;
      chk("r8", o_receiver8_digital_out, m[1]);
      chk("t4p", o_transmitter4_positive_out, i_transmitter4_digital_in);
      chk("t4n", o_transmitter4_negative_out, m > 2 && !i_transmitter4_digital_in);
      chk("t4oe", o_transmitter4_negative_oe, m > 2);
      chk("t5n", o_transmitter5_negative_out, m > 2 && !i_transmitter5_digital_in);
      chk("t5oe", o_transmitter5_negative_oe, m > 2);
      chk("r8oe", o_receiver8_digital_oe, !m[2]);
      chk("lb off", o_loopback_active, 0);
    end
    {i_latch_select, i_sample_clk, sig} = 8'hC0;
    step(1);
    {i_sample_clk, i_receiver5_line_in, sig} = 8'h7F;
    step(3);
    chk("t5 hold", o_transmitter5_positive_out, 0);
    chk("r5 hold", o_receiver5_digital_out, 0);
    i_sample_clk = 1;
    step(1);
    chk("t8 load", o_transmitter8_line_out, 1);
    chk("r5 load", o_receiver5_digital_out, 1);
    {i_latch_select, i_loopback_n, i_receiver5_line_in} = 0;
    for (int r = 0; r < 2; r++)
    begin
      i_role_select = r[0];
      step(1);
      chk("r5 loop", o_receiver5_digital_out, 1);
      chk("t5 loop", o_transmitter5_positive_out, !r[0]);
      chk("t8 loop", o_transmitter8_line_out, !r[0]);
      chk("lb on", o_loopback_active, 1);
    end
    complete_run;
  end
endmodule
